// *** verilog/sdac_host.sv ***
// host controller end: sends a word and strobes the latch
`timescale 1ns/10ps
module sdac_host (
    input wire logic sys_clk,
    input wire logic reset_n,
    sdac_link_if.host link,
    input wire logic send_req,
    input wire logic [15:0] send_word,
    input wire logic [7:0] send_bits,
    input wire logic do_shift,
    input wire logic do_load,
    input wire logic clear_req,
    output logic busy,
    output logic done,
    output logic last_out_bit
);
    typedef enum logic [2:0] {
        SDAC_IDLE = 3'b000,
        SDAC_LOW = 3'b001,
        SDAC_HIGH = 3'b010,
        SDAC_CLEAR = 3'b011,
        SDAC_DONE = 3'b100
    } sdac_state_t;

    // ****************************************
    // sequencer
    // ****************************************
    sdac_state_t state_reg;
    sdac_state_t state_next;
    logic [15:0] word_reg;
    logic [15:0] word_next;
    logic [7:0] bits_reg;
    logic [7:0] bits_next;
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic shen_reg;
    logic shen_next;
    logic lden_reg;
    logic lden_next;
    logic sout_reg;
    logic sout_next;
    localparam logic [7:0] HALF = 8'(sdac_pkg::STROBE_HALF_CYC);
    localparam logic [7:0] CLR_LEN = 8'(sdac_pkg::CLEAR_CYC);

    always_comb
    begin
        state_next = state_reg;
        word_next = word_reg;
        bits_next = bits_reg;
        cnt_next = cnt_reg;
        shen_next = shen_reg;
        lden_next = lden_reg;
        sout_next = sout_reg;
        unique case (state_reg)
            SDAC_IDLE:
            begin
                shen_next = 1'b1;
                lden_next = 1'b1;
                if (clear_req)
                begin
                    cnt_next = CLR_LEN;
                    state_next = SDAC_CLEAR;
                end
                else if (send_req && (do_shift || do_load))
                begin
                    word_next = send_word;
                    // send_bits strobes when shifting, a single strobe for a load alone
                    bits_next = do_shift ? send_bits : 8'h01;
                    shen_next = ~do_shift;
                    lden_next = ~do_load;
                    cnt_next = HALF;
                    state_next = SDAC_LOW;
                end
            end
            SDAC_LOW:
            begin
                if (cnt_reg == 8'h01)
                begin
                    cnt_next = HALF;
                    state_next = SDAC_HIGH;
                end
                else
                    cnt_next = cnt_reg - 8'h01;
            end
            SDAC_HIGH:
            begin
                if (cnt_reg == 8'h01)
                begin
                    sout_next = link.serial_out;
                    word_next = {word_reg[14:0], 1'b0};
                    bits_next = bits_reg - 8'h01;
                    cnt_next = HALF;
                    state_next = (bits_reg == 8'h01) ? SDAC_DONE : SDAC_LOW;
                end
                else
                    cnt_next = cnt_reg - 8'h01;
            end
            SDAC_CLEAR:
            begin
                if (cnt_reg == 8'h01)
                    state_next = SDAC_DONE;
                else
                    cnt_next = cnt_reg - 8'h01;
            end
            SDAC_DONE:
            begin
                shen_next = 1'b1;
                lden_next = 1'b1;
                state_next = SDAC_IDLE;
            end
            default:
                state_next = SDAC_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            state_reg <= SDAC_IDLE;
            word_reg <= 16'h0000;
            bits_reg <= 8'h00;
            cnt_reg <= 8'h00;
            shen_reg <= 1'b1;
            lden_reg <= 1'b1;
            sout_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            word_reg <= word_next;
            bits_reg <= bits_next;
            cnt_reg <= cnt_next;
            shen_reg <= shen_next;
            lden_reg <= lden_next;
            sout_reg <= sout_next;
        end
    end

    // ****************************************
    // pins
    // ****************************************
    assign link.strobe_n = (state_reg != SDAC_LOW);
    assign link.serial_in = word_reg[15];
    assign link.shift_enable_n = shen_reg;
    assign link.dac_latch_enable_n = lden_reg;
    assign link.clear_n = (state_reg != SDAC_CLEAR);
    assign busy = (state_reg != SDAC_IDLE);
    assign done = (state_reg == SDAC_DONE);
    assign last_out_bit = sout_reg;
endmodule

// *** verilog/sdac_pkg.sv ***
// package of constants for the serial converter input logic
package sdac_pkg;
    localparam int WORD_BITS = 16;
    localparam logic [15:0] CLEAR_CODE = 16'h0000;
    localparam logic [15:0] POS_FULL_CODE = 16'h7fff;
    localparam logic [15:0] NEG_FULL_CODE = 16'h8000;
    localparam logic [15:0] BIPOLAR_ZERO_CODE = 16'h0000;
    // strobe half period in sys_clk cycles (50 ns min at 20 ns)
    localparam int STROBE_HALF_NS = 50;
    localparam int CLK_PERIOD_NS = 20;
    localparam int STROBE_HALF_CYC =
        (STROBE_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // clear pulse width
    localparam int CLEAR_NS = 200;
    localparam int CLEAR_CYC = (CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_BITS = 8;
    localparam int BIT_BITS = 5;
endpackage

// *** verilog/sdac_link_if.sv ***
// interface joining host controller and converter input logic
`timescale 1ns/10ps
interface sdac_link_if;
    logic strobe_n;
    logic serial_in;
    logic shift_enable_n;
    logic dac_latch_enable_n;
    logic clear_n;
    logic serial_out;
    modport device (
        input strobe_n,
        input serial_in,
        input shift_enable_n,
        input dac_latch_enable_n,
        input clear_n,
        output serial_out
    );
    modport host (
        output strobe_n,
        output serial_in,
        output shift_enable_n,
        output dac_latch_enable_n,
        output clear_n,
        input serial_out
    );
endinterface

// *** verilog/sdac_device.sv ***
// converter input logic: shift register and converter latch
`timescale 1ns/10ps
module sdac_device (
    input wire logic sys_clk,
    input wire logic reset_n,
    sdac_link_if.device link,
    output logic [15:0] dac_code,
    output logic at_bipolar_zero,
    output logic at_pos_full,
    output logic at_neg_full
);
    // ****************************************
    // strobe edge detection
    // ****************************************
    logic strobe_prev_reg;
    logic strobe_prev_next;
    logic [15:0] shift_reg;
    logic [15:0] shift_next;
    logic [15:0] latch_reg;
    logic [15:0] latch_next;
    logic rise;

    // strobe completes 1 -> 0 -> 1 on the rising edge
    assign rise = link.strobe_n & ~strobe_prev_reg;

    always_comb
    begin
        strobe_prev_next = link.strobe_n;
        shift_next = shift_reg;
        latch_next = latch_reg;
        if (!link.clear_n)
        begin
            shift_next = sdac_pkg::CLEAR_CODE;
            latch_next = sdac_pkg::CLEAR_CODE;
        end
        else if (rise)
        begin
            if (!link.shift_enable_n)
                shift_next = {shift_reg[14:0], link.serial_in};
            if (!link.dac_latch_enable_n)
            begin
                // two-wire mode passes the fresh word straight through
                if (!link.shift_enable_n)
                    latch_next = {shift_reg[14:0], link.serial_in};
                else
                    latch_next = shift_reg;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            strobe_prev_reg <= 1'b1;
            shift_reg <= sdac_pkg::CLEAR_CODE;
            latch_reg <= sdac_pkg::CLEAR_CODE;
        end
        else
        begin
            strobe_prev_reg <= strobe_prev_next;
            shift_reg <= shift_next;
            latch_reg <= latch_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign link.serial_out = shift_reg[15];
    assign dac_code = latch_reg;
    // two's complement code points
    assign at_bipolar_zero =
        (latch_reg == sdac_pkg::BIPOLAR_ZERO_CODE);
    assign at_pos_full = (latch_reg == sdac_pkg::POS_FULL_CODE);
    assign at_neg_full = (latch_reg == sdac_pkg::NEG_FULL_CODE);
endmodule

// *** dv/sdac_link_properties.sv ***
// checker watching the host to converter link
`timescale 1ns/10ps
module sdac_link_props (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic strobe_n,
    input wire logic serial_in,
    input wire logic shift_enable_n,
    input wire logic dac_latch_enable_n,
    input wire logic clear_n,
    input wire logic serial_out,
    input wire logic [15:0] dac_code
);
    logic prev_reg, prev_next, rise;
    logic [15:0] shad_reg, shad_next;
    // ************************************
    // shadow of the input shift stage
    // ************************************
    assign rise = strobe_n && !prev_reg;
    always_comb
    begin
        prev_next = strobe_n;
        shad_next = shad_reg;
        if (!clear_n)
            shad_next = 16'h0000;
        else if (rise && !shift_enable_n)
            shad_next = {shad_reg[14:0], serial_in};
    end
    always_ff @(posedge sys_clk)
    begin
        prev_reg <= reset_n ? prev_next : 1'b1;
        shad_reg <= reset_n ? shad_next : 16'h0000;
    end
    // ************************************
    // properties
    // ************************************
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    a_hold_no_strobe: assert property (!rise && clear_n |=>
        $stable(dac_code) && $stable(serial_out))
        else $error("state moved without a strobe");
    a_clear_zeroes: assert property (!clear_n |=>
        dac_code == 16'h0000 && !serial_out)
        else $error("clear did not zero both stages");
    a_load_copies: assert property (rise && !dac_latch_enable_n
        && clear_n |=> dac_code == shad_reg)
        else $error("latch not loaded from input stage");
    a_latch_needs_enable: assert property (rise && dac_latch_enable_n
        && clear_n |=> $stable(dac_code))
        else $error("latch changed without its enable");
    a_both_high_hold: assert property (rise && shift_enable_n
        && clear_n |=> $stable(serial_out))
        else $error("shift stage moved with its enable high");
    a_out_is_msb: assert property (serial_out == shad_reg[15])
        else $error("serial output not the top stage");
    a_strobe_low_width: assert property ($fell(strobe_n) |=>
        !strobe_n ##1 !strobe_n ##1 strobe_n)
        else $error("strobe low phase wrong length");
    a_enables_steady: assert property (!strobe_n |=>
        $stable(shift_enable_n) && $stable(dac_latch_enable_n))
        else $error("enable moved while strobe low");
    a_clear_width: assert property ($fell(clear_n) |->
        !clear_n [*8] ##1 !clear_n ##1 !clear_n ##1 clear_n)
        else $error("clear pulse wrong length");
    cover property (rise && !shift_enable_n && !dac_latch_enable_n);
    cover property (rise && shift_enable_n && !dac_latch_enable_n);
    cover property ($fell(clear_n));
endmodule

// *** dv/tb.sv ***
// self-checking bench joining host and converter ends
`timescale 1ns/10ps
module tb;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic send_req = 1'b0;
    logic do_shift = 1'b0;
    logic do_load = 1'b0;
    logic clear_req = 1'b0;
    logic [15:0] send_word = 16'h0000;
    logic [7:0] send_bits = 8'h10;
    logic busy, done, last_out_bit, prev_strobe;
    logic at_bipolar_zero, at_pos_full, at_neg_full;
    logic [15:0] dac_code, cap_in, cap_out;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    int strobes = 0;
    sdac_link_if link();
    sdac_device i_sdac_device (.sys_clk(sys_clk), .reset_n(reset_n),
        .link(link), .dac_code(dac_code), .at_bipolar_zero(at_bipolar_zero),
        .at_pos_full(at_pos_full), .at_neg_full(at_neg_full));
    sdac_host i_sdac_host (.sys_clk(sys_clk), .reset_n(reset_n),
        .link(link), .send_req(send_req), .send_word(send_word),
        .send_bits(send_bits), .do_shift(do_shift), .do_load(do_load),
        .clear_req(clear_req), .busy(busy), .done(done),
        .last_out_bit(last_out_bit));
    sdac_link_props i_sdac_link_props (.sys_clk(sys_clk), .reset_n(reset_n),
        .strobe_n(link.strobe_n), .serial_in(link.serial_in),
        .shift_enable_n(link.shift_enable_n),
        .dac_latch_enable_n(link.dac_latch_enable_n),
        .clear_n(link.clear_n), .serial_out(link.serial_out),
        .dac_code(dac_code));
    always #10 sys_clk = ~sys_clk;
    // wire capture at each shifting strobe rise
    always @(posedge sys_clk)
    begin
        prev_strobe <= link.strobe_n;
        if (link.strobe_n && !prev_strobe)
            strobes <= strobes + 1;
        if (link.strobe_n && !prev_strobe && !link.shift_enable_n)
        begin
            cap_in <= {cap_in[14:0], link.serial_in};
            cap_out <= {cap_out[14:0], link.serial_out};
        end
    end
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            final_report();
        end
    end
    task automatic final_report;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic send(input logic [15:0] w, input logic [7:0] b,
        input logic sh, input logic ld);
        int pulses;
        int s0;
        pulses = 0;
        step;
        s0 = strobes;
        send_word = w;
        send_bits = b;
        do_shift = sh;
        do_load = ld;
        send_req = 1'b1;
        step;
        send_req = 1'b0;
        while (busy === 1'b1)
        begin
            if (done === 1'b1)
                pulses++;
            step;
        end
        check(16'(pulses), 16'h0001);
        check(16'(strobes - s0), sh ? {8'h00, b} : 16'h0001);
    endtask
    task automatic t_shift_load;
        send(16'h7fff, 8'h10, 1'b1, 1'b0);
        check(cap_in, 16'h7fff);
        check(dac_code, 16'h0000);
        send(16'h0000, 8'h10, 1'b0, 1'b1);
        check(dac_code, 16'h7fff);
        check({15'h0000, at_pos_full}, 16'h0001);
        $display("test shift_load end");
    endtask
    task automatic t_two_wire;
        send(16'h8000, 8'h10, 1'b1, 1'b1);
        check(dac_code, 16'h8000);
        check({15'h0000, at_neg_full}, 16'h0001);
        check({15'h0000, last_out_bit}, 16'h0001);
        $display("test two_wire end");
    endtask
    task automatic t_cascade;
        send(16'hbeef, 8'h20, 1'b1, 1'b0);
        check(cap_out, 16'hbeef);
        check(cap_in, 16'h0000);
        check({15'h0000, last_out_bit}, 16'h0000);
        check(dac_code, 16'h8000);
        $display("test cascade end");
    endtask
    task automatic t_clear;
        step;
        clear_req = 1'b1;
        step;
        clear_req = 1'b0;
        while (busy === 1'b1)
            step;
        check(dac_code, 16'h0000);
        check({15'h0000, at_bipolar_zero}, 16'h0001);
        $display("test clear end");
    endtask
    initial
    begin
        repeat (3) @(posedge sys_clk);
        #1;
        reset_n = 1'b1;
        t_shift_load();
        t_two_wire();
        t_cascade();
        t_clear();
        final_report();
    end
endmodule
